// ==== include/uart_pkg.sv ====
// constants, types and helpers shared by the serial port design
package uart_pkg;
   // byte offsets on the register bus
   localparam logic [7:0] A_DATA = 8'h00;
   localparam logic [7:0] A_DIVL = 8'h04;
   localparam logic [7:0] A_DIVH = 8'h08;
   localparam logic [7:0] A_LCTL = 8'h0c;
   localparam logic [7:0] A_GCTL = 8'h10;
   localparam logic [7:0] A_STAT = 8'h14;
   localparam logic [7:0] A_MASK = 8'h18;
   // global control fields
   localparam int GC_EN   = 0;
   localparam int GC_DIV1 = 1;
   localparam int GC_IRDA = 2;
   localparam int GC_DMA  = 3;
   localparam int GC_CTS  = 4;
   localparam int GC_ARTS = 5;
   localparam int GC_THR  = 6;
   localparam int GC_TXSH = 7;
   localparam int GC_PRI  = 8;
   localparam int GC_W    = 10;
   // line control fields
   localparam int LC_WL  = 0;
   localparam int LC_STB = 2;
   localparam int LC_PEN = 3;
   localparam int LC_POD = 4;
   localparam int LC_W   = 5;
   // sticky status bits and live status position
   localparam int ST_RX   = 0;
   localparam int ST_TX   = 1;
   localparam int ST_PE   = 2;
   localparam int ST_FE   = 3;
   localparam int ST_OE   = 4;
   localparam int NEV     = 5;
   localparam int ST_LIVE = 8;
   // reset values
   localparam logic [GC_W-1:0] GC_RST  = 10'h000;
   localparam logic [LC_W-1:0] LC_RST  = 5'h03;
   localparam logic [15:0]     DIV_RST = 16'h0001;
   localparam logic [15:0]     DIV_ONE = 16'h0001;
   // last tick of a bit at 16x, centre point, last tick of the infrared pulse
   localparam logic [3:0] OVS_LAST = 4'hf;
   localparam logic [3:0] OVS_HALF = 4'h7;
   localparam logic [3:0] IR_LAST  = 4'h2;

   typedef enum logic [2:0] {
      S_IDLE, S_START, S_DATA, S_PAR, S_STOP
   } ser_state_t;

   // index of the last data bit: 4..7 for 5..8 bits
   function automatic logic [2:0] last_bit(input logic [1:0] wl);
      last_bit = {1'b1, wl};
   endfunction : last_bit

   // parity bit for the low data bits of d
   function automatic logic par_of(input logic [7:0] d,
                                   input logic [1:0] wl,
                                   input logic       odd);
      par_of = ^(d & (8'hff >> (3'h7 - last_bit(wl)))) ^ odd;
   endfunction : par_of
endpackage : uart_pkg

// ==== hdl/baud_tick.sv ====
// bit clock divider: one tick per divisor period of the system clock
`timescale 1ns/1ps
`default_nettype none
module baud_tick (
   input  wire logic        clock,
   input  wire logic        arst_n,
   input  wire logic        run,
   input  wire logic [15:0] divisor,
   output logic             tick
);
   import uart_pkg::*;

   logic [15:0] cnt;
   logic [15:0] next_cnt;
   logic        next_tick;

   // zero divisor reloads 65535, i.e. 65536 clocks, the slowest rate
   always_comb begin
      next_cnt  = cnt - DIV_ONE;
      next_tick = 1'b0;
      if (!run) begin
         next_cnt = divisor - DIV_ONE;
      end else if (cnt == 16'h0000) begin
         next_cnt  = divisor - DIV_ONE;
         next_tick = 1'b1;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         cnt  <= 16'h0000;
         tick <= 1'b0;
      end else begin
         cnt  <= next_cnt;
         tick <= next_tick;
      end
   end

   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);

   chk_tick_spacing: assert property (
      (tick && run && divisor == 16'h0002 && $stable(divisor))
      |=> !tick ##1 (tick || !run))
      else $error("tick spacing wrong for divisor two");
endmodule : baud_tick
`default_nettype wire

// ==== hdl/async_serial_port.sv ====
// serial port core: bus registers, transmitter, receiver, interrupt
//
// Chosen here: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module async_serial_port (
   input  wire logic        clock,
   input  wire logic        arst_n,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        serial_in,
   output logic             serial_out,
   input  wire logic        clear_to_send_in,
   output logic             request_to_send_out,
   output logic             rx_line_to_timer,
   output logic             tx_dma_req,
   output logic             rx_dma_req,
   output logic [1:0]       dma_priority,
   output logic             irq
);
   import uart_pkg::*;

   logic [15:0]     div, next_div;
   logic [LC_W-1:0] lc, next_lc;
   logic [GC_W-1:0] gc, next_gc;
   logic [NEV-1:0]  st, next_st, mask, next_mask, w1c;
   logic [31:0]     next_rdat, rmux;
   logic            next_ack, done, wr, pop, wdat;
   logic [7:0]      a, thold, next_thold, rhold, next_rhold;
   logic            tfull, next_tfull, rfull, next_rfull;
   logic            ev_tx, ev_oe, next_rts, en, irda, tick, tlast;
   logic [3:0]      tl;
   logic            rx_s1, rx_s, cts_s1, cts_s;
   // transmitter state
   ser_state_t      ts, next_ts;
   logic [3:0]      tcnt, next_tcnt;
   logic [2:0]      tbit, next_tbit;
   logic [7:0]      tsh, next_tsh;
   logic            tpar, next_tpar, tstop, next_tstop;
   logic            txd, next_txd, next_sout, tx_take, tx_end, tbend;
   // receiver state
   ser_state_t      rs, next_rs;
   logic [3:0]      rcnt, next_rcnt, str, next_str;
   logic [2:0]      rbit, next_rbit;
   logic [7:0]      rsh, next_rsh, rword;
   logic            rline, rx_done, rperr, next_rperr, rsamp;

   assign a    = {wb_adr_i[7:2], 2'b00};
   assign en   = gc[GC_EN];
   assign irda = gc[GC_IRDA];
   assign tl   = gc[GC_DIV1] ? 4'h0 : OVS_LAST;

   baud_tick baud_tick_inst (
      .clock   (clock),
      .arst_n  (arst_n),
      .run     (en),
      .divisor (div),
      .tick    (tick)
   );

   // pin synchronisers; first stages feed only the second
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rx_s1  <= 1'b1;
         rx_s   <= 1'b1;
         cts_s1 <= 1'b0;
         cts_s  <= 1'b0;
      end else begin
         rx_s1  <= serial_in;
         rx_s   <= rx_s1;
         cts_s1 <= clear_to_send_in;
         cts_s  <= cts_s1;
      end
   end

   // register read mux
   always_comb begin
      case (a)
         A_DATA:  rmux = {24'h0, rhold};
         A_DIVL:  rmux = {24'h0, div[7:0]};
         A_DIVH:  rmux = {24'h0, div[15:8]};
         A_LCTL:  rmux = {27'h0, lc};
         A_GCTL:  rmux = {22'h0, gc};
         A_STAT:  rmux = {20'h0, cts_s, (ts == S_IDLE) & ~tfull,
                          ~tfull, rfull, 3'h0, st};
         A_MASK:  rmux = {27'h0, mask};
         default: rmux = 32'h0;
      endcase
   end

   // bus slave and register file; effects land on the edge ack is seen
   always_comb begin
      next_ack   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
      done       = wb_cyc_i & wb_stb_i & wb_ack_o;
      wr         = done & wb_we_i & wb_sel_i[0];
      pop        = done & ~wb_we_i & (a == A_DATA);
      wdat       = wr & (a == A_DATA);
      w1c        = (wr && a == A_STAT) ? wb_dat_i[NEV-1:0] : '0;
      next_rdat  = next_ack ? rmux : wb_dat_o;
      next_div   = div;
      next_lc    = lc;
      next_gc    = gc;
      next_mask  = mask;
      if (wr) begin
         case (a)
            A_DIVL:  next_div[7:0]  = wb_dat_i[7:0];
            A_DIVH:  next_div[15:8] = wb_dat_i[7:0];
            A_LCTL:  next_lc   = wb_dat_i[LC_W-1:0];
            A_GCTL:  next_gc   = wb_dat_i[GC_W-1:0];
            A_MASK:  next_mask = wb_dat_i[NEV-1:0];
            default: ;
         endcase
      end
      // a write into a full holding register is dropped unless tx_take empties it that cycle
      next_tfull = (tfull & ~tx_take) | (wdat & (~tfull | tx_take));
      next_thold = (wdat & (~tfull | tx_take)) ? wb_dat_i[7:0] : thold;
      // overrun keeps the older character, the newer is lost
      ev_oe      = rx_done & rfull & ~pop;
      next_rfull = (rfull & ~pop) | (rx_done & ~ev_oe);
      next_rhold = (rx_done & ~ev_oe) ? rword : rhold;
      // transmit event timing chosen by software
      ev_tx = gc[GC_TXSH] ? (tx_end & ~tfull) : tx_take;
      // sticky flags: a set in the clearing cycle wins
      next_st = st & ~w1c;
      next_st[ST_RX] = next_st[ST_RX] | rx_done;
      next_st[ST_TX] = next_st[ST_TX] | ev_tx;
      next_st[ST_PE] = next_st[ST_PE] | (rx_done & rperr);
      next_st[ST_FE] = next_st[ST_FE] | (rx_done & ~rsamp);
      next_st[ST_OE] = next_st[ST_OE] | ev_oe;
      // fill counts holding register plus a character in flight
      next_rts = ~(gc[GC_ARTS] &
                   (({1'b0, rfull} + {1'b0, rs != S_IDLE}) >
                    {1'b0, gc[GC_THR]}));
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         wb_ack_o            <= 1'b0;
         wb_dat_o            <= 32'h0;
         div                 <= DIV_RST;
         lc                  <= LC_RST;
         gc                  <= GC_RST;
         mask                <= '0;
         st                  <= '0;
         tfull               <= 1'b0;
         thold               <= 8'h00;
         rfull               <= 1'b0;
         rhold               <= 8'h00;
         request_to_send_out <= 1'b1;
      end else begin
         wb_ack_o            <= next_ack;
         wb_dat_o            <= next_rdat;
         div                 <= next_div;
         lc                  <= next_lc;
         gc                  <= next_gc;
         mask                <= next_mask;
         st                  <= next_st;
         tfull               <= next_tfull;
         thold               <= next_thold;
         rfull               <= next_rfull;
         rhold               <= next_rhold;
         request_to_send_out <= next_rts;
      end
   end

   // interrupt level and dma requests; priority resets to lowest
   assign irq          = |(st & mask);
   assign tx_dma_req   = gc[GC_DMA] & en & ~tfull;
   assign rx_dma_req   = gc[GC_DMA] & rfull;
   assign dma_priority = gc[GC_PRI +: 2];

   // transmitter, runs independent of the receiver
   always_comb begin
      next_ts    = ts;
      next_tcnt  = tcnt;
      next_tbit  = tbit;
      next_tsh   = tsh;
      next_tpar  = tpar;
      next_tstop = tstop;
      next_txd   = txd;
      tx_take    = 1'b0;
      tx_end     = 1'b0;
      tbend      = tick & (tcnt == tl);
      if (tick) begin
         next_tcnt = tbend ? 4'h0 : tcnt + 4'h1;
      end
      unique case (ts)
         S_IDLE: begin
            next_tcnt = 4'h0;
            next_txd  = 1'b1;
            if (tick && en && tfull && (~gc[GC_CTS] | cts_s)) begin
               tx_take   = 1'b1;
               next_ts   = S_START;
               next_txd  = 1'b0;
               next_tsh  = thold;
               next_tbit = 3'h0;
               next_tpar = par_of(thold, lc[LC_WL +: 2], lc[LC_POD]);
            end
         end
         S_START: if (tbend) begin
            next_ts  = S_DATA;
            next_txd = tsh[0];
         end
         S_DATA: if (tbend) begin
            if (tbit == last_bit(lc[LC_WL +: 2])) begin
               next_ts    = lc[LC_PEN] ? S_PAR : S_STOP;
               next_txd   = lc[LC_PEN] ? tpar : 1'b1;
               next_tstop = lc[LC_STB];
            end else begin
               next_tsh  = tsh >> 1;
               next_txd  = tsh[1];
               next_tbit = tbit + 3'h1;
            end
         end
         S_PAR: if (tbend) begin
            next_ts    = S_STOP;
            next_txd   = 1'b1;
            next_tstop = lc[LC_STB];
         end
         S_STOP: if (tbend) begin
            if (tstop) begin
               next_tstop = 1'b0; // second stop bit
            end else begin
               tx_end  = 1'b1;
               next_ts = S_IDLE;
            end
         end
      endcase
      if (!en) begin
         next_ts = S_IDLE;
      end
      // infrared: short high pulse for a zero, dark otherwise
      if (irda) begin
         next_sout = ~next_txd & (next_ts != S_IDLE) &
                     (next_tcnt <= IR_LAST);
      end else begin
         next_sout = next_txd;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         ts         <= S_IDLE;
         tcnt       <= 4'h0;
         tbit       <= 3'h0;
         tsh        <= 8'h00;
         tpar       <= 1'b0;
         tstop      <= 1'b0;
         txd        <= 1'b1;
         serial_out <= 1'b1;
      end else begin
         ts         <= next_ts;
         tcnt       <= next_tcnt;
         tbit       <= next_tbit;
         tsh        <= next_tsh;
         tpar       <= next_tpar;
         tstop      <= next_tstop;
         txd        <= next_txd;
         serial_out <= next_sout;
      end
   end

   // infrared pulses are stretched over a bit so the sampler sees them
   assign rline            = irda ? ~(rx_s | (str != 4'h0)) : rx_s;
   assign rx_line_to_timer = rline;
   assign rsamp            = rline;
   assign tlast            = (rcnt == tl);
   assign rword = rsh >> (3'h7 - last_bit(lc[LC_WL +: 2]));

   // receiver, runs independent of the transmitter
   always_comb begin
      next_rs    = rs;
      next_rcnt  = rcnt;
      next_rbit  = rbit;
      next_rsh   = rsh;
      next_rperr = rperr;
      rx_done    = 1'b0;
      next_str   = str;
      if (irda && rx_s) begin
         next_str = OVS_LAST;
      end else if (tick && str != 4'h0) begin
         next_str = str - 4'h1;
      end
      unique case (rs)
         S_IDLE: begin
            next_rcnt  = 4'h0;
            next_rbit  = 3'h0;
            next_rperr = 1'b0;
            if (en && tick && !rline) begin
               next_rs = gc[GC_DIV1] ? S_DATA : S_START;
            end
         end
         S_START: if (tick) begin
            if (rcnt == OVS_HALF) begin
               next_rcnt = 4'h0;
               next_rs   = rline ? S_IDLE : S_DATA;
            end else begin
               next_rcnt = rcnt + 4'h1;
            end
         end
         S_DATA: if (tick) begin
            next_rcnt = tlast ? 4'h0 : rcnt + 4'h1;
            if (tlast) begin
               next_rsh = {rline, rsh[7:1]};
               if (rbit == last_bit(lc[LC_WL +: 2])) begin
                  next_rs = lc[LC_PEN] ? S_PAR : S_STOP;
               end else begin
                  next_rbit = rbit + 3'h1;
               end
            end
         end
         S_PAR: if (tick) begin
            next_rcnt = tlast ? 4'h0 : rcnt + 4'h1;
            if (tlast) begin
               next_rperr = rline !=
                  par_of(rword, lc[LC_WL +: 2], lc[LC_POD]);
               next_rs = S_STOP;
            end
         end
         S_STOP: if (tick) begin
            next_rcnt = tlast ? 4'h0 : rcnt + 4'h1;
            if (tlast) begin
               rx_done = 1'b1; // only the first stop bit is checked
               next_rs = S_IDLE;
            end
         end
      endcase
      if (!en) begin
         next_rs = S_IDLE;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rs    <= S_IDLE;
         rcnt  <= 4'h0;
         rbit  <= 3'h0;
         rsh   <= 8'h00;
         rperr <= 1'b0;
         str   <= 4'h0;
      end else begin
         rs    <= next_rs;
         rcnt  <= next_rcnt;
         rbit  <= next_rbit;
         rsh   <= next_rsh;
         rperr <= next_rperr;
         str   <= next_str;
      end
   end

   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);

   chk_tx_start_low: assert property (
      tx_take |=> (ts == S_START && txd == 1'b0))
      else $error("start bit not low after take");
   chk_cts_blocks: assert property (
      (ts == S_IDLE && gc[GC_CTS] && !cts_s) |-> !tx_take)
      else $error("character started without clear to send");
   chk_rts_drop: assert property (
      (gc[GC_ARTS] && rfull && !gc[GC_THR]) |=> !request_to_send_out)
      else $error("request to send not dropped");
   chk_irq_unmasked: assert property (
      ($rose(st[ST_RX]) && mask[ST_RX]) |-> irq)
      else $error("unmasked receive event gave no interrupt");
   chk_perr_sticky: assert property (
      (rx_done && rperr) |=> st[ST_PE] ##1 (st[ST_PE] || $past(w1c[ST_PE])))
      else $error("parity error flag not held");
   chk_rx_hold_load: assert property (
      (rx_done && !rfull) |=> (rfull && rhold == $past(rword)))
      else $error("received character not buffered");
   chk_tx_dma_fill: assert property (
      (tx_dma_req && wdat && !tx_take) |=> (tfull && !tx_dma_req))
      else $error("dma write did not fill holding register");
   chk_stop_high: assert property (
      (ts == S_STOP && !irda) |-> txd)
      else $error("stop bit not high");
endmodule : async_serial_port
`default_nettype wire

// ==== test/serial_remote.sv ====
// remote serial party: catches device frames and sends characters back
`timescale 1ns/1ps
`default_nettype none
module serial_remote #(
   parameter int BIT = 16
) (
   input  wire logic clock,
   input  wire logic line_in,
   input  wire logic rts_in,
   output logic      line_out,
   output logic      cts_out
);
   logic        cts_grant = 1'b1;
   int          nsamp     = 12;
   logic [11:0] frames [$];

   // the grant is held by the bench, changed only after a clock edge
   assign cts_out = cts_grant;
   initial line_out = 1'b1;

   // centre-sample nsamp bit periods from the falling start edge
   always begin : catcher
      logic [11:0] f;
      @(negedge line_in);
      f = 12'hfff;
      repeat (BIT / 2) @(posedge clock);
      for (int i = 0; i < nsamp; i++) begin
         if (i > 0) repeat (BIT) @(posedge clock);
         f[i] = line_in;
      end
      frames.push_back(f);
   end

   // one bit period on the line
   task automatic put(input logic b);
      line_out <= b;
      repeat (BIT) @(posedge clock);
   endtask : put

   // one character, lsb first; stp low makes a framing fault on purpose
   task automatic send(input logic [7:0] d, input int nb, input logic pe,
                       input logic pb, input logic stp);
      wait (rts_in === 1'b1);
      @(posedge clock);
      put(1'b0);
      for (int i = 0; i < nb; i++) put(d[i]);
      if (pe) put(pb);
      put(stp);
      put(1'b1);
   endtask : send
endmodule : serial_remote
`default_nettype wire

// ==== test/async_serial_port_bench.sv ====
// self-checking bench for the serial port against a remote line model
`timescale 1ns/1ps
`default_nettype none
module async_serial_port_bench;
   import uart_pkg::*;
   logic        clock      = 1'b0;
   logic        arst_n     = 1'b0;
   logic        cyc        = 1'b0;
   logic        stb        = 1'b0;
   logic        we         = 1'b0;
   logic [7:0]  adr        = 8'h00;
   logic [3:0]  sel        = 4'h0;
   logic [31:0] wdat       = 32'h0;
   logic [31:0] rdat;
   logic        ack, sin, sout, cts, rts, rxt, txd, rxd, irq;
   logic [1:0]  prio;
   int          err_total  = 0;
   int          n_compared = 0;

   always #25 clock = ~clock;

   async_serial_port async_serial_port_inst (
      .clock(clock), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .serial_in(sin),
      .serial_out(sout), .clear_to_send_in(cts),
      .request_to_send_out(rts), .rx_line_to_timer(rxt),
      .tx_dma_req(txd), .rx_dma_req(rxd), .dma_priority(prio), .irq(irq));

   serial_remote #(.BIT(16)) remote_inst (
      .clock(clock), .line_in(sout), .rts_in(rts), .line_out(sin),
      .cts_out(cts));

   task automatic check(input string what, input logic [31:0] exp,
                        input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   // one classic cycle, held until ack is sampled high
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clock);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= 4'hf;
      do begin
         @(posedge clock);
         n++;
      end while (ack !== 1'b1 && n < 20);
      q = rdat;
      if (ack !== 1'b1) check("bus ack", 32'h1, 32'h0);
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : xfer

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b1, a, d, q);
   endtask : wr

   task automatic rd_chk(input string what, input logic [7:0] a,
                         input logic [31:0] m, input logic [31:0] exp);
      logic [31:0] q;
      xfer(1'b0, a, 32'h0, q);
      check(what, exp, q & m);
   endtask : rd_chk

   // idle high, low start, lsb first, parity, high stops, idle after
   function automatic logic [11:0] frame_of(input logic [7:0] d,
                                            input logic [4:0] lc);
      logic [11:0] f;
      int          n;
      f = 12'hffe;
      n = int'(lc[1:0]) + 5;
      for (int i = 0; i < n; i++) f[i+1] = d[i];
      if (lc[3]) f[n+1] = ^(d & (8'hff >> (8 - n))) ^ lc[4];
      return f;
   endfunction : frame_of

   // bounded wait for the partner to catch a frame
   task automatic expect_frame(input string what, input logic [11:0] exp);
      int n;
      n = 0;
      while (remote_inst.frames.size() == 0 && n < 600) begin
         @(posedge clock);
         n++;
      end
      if (remote_inst.frames.size() == 0) check(what, 32'h1, 32'h0);
      else check(what, {20'h0, exp}, {20'h0, remote_inst.frames.pop_front()});
      repeat (16) @(posedge clock);
   endtask : expect_frame

   task automatic t_reset;
      rd_chk("divl", A_DIVL, 32'hff, 32'h01);
      rd_chk("divh", A_DIVH, 32'hff, 32'h00);
      rd_chk("lctl", A_LCTL, 32'h1f, 32'h03);
      rd_chk("gctl", A_GCTL, 32'h3ff, 32'h0);
      rd_chk("stat", A_STAT, 32'h71f, 32'h600);
      rd_chk("unmapped", 8'h1c, 32'hffffffff, 32'h0);
      check("prio", 32'h0, {30'h0, prio});
      check("timer line", 32'h1, {31'h0, rxt});
   endtask : t_reset

   task automatic t_tx_formats;
      logic [4:0] lc [3];
      logic [7:0] dv [3];
      lc = '{5'h00, 5'h1f, 5'h0a};
      dv = '{8'h96, 8'h3b, 8'h71};
      wr(A_GCTL, 32'h1);
      for (int i = 0; i < 3; i++) begin
         wr(A_LCTL, {27'h0, lc[i]});
         wr(A_DATA, {24'h0, dv[i]});
         expect_frame("tx frame", frame_of(dv[i], lc[i]));
      end
   endtask : t_tx_formats

   // divide-by-one with divisor 16 gives the same bit period as 16x
   task automatic t_div_one;
      wr(A_DIVL, 32'h10);
      wr(A_GCTL, 32'h3);
      wr(A_LCTL, 32'h3);
      wr(A_DATA, 32'hc4);
      expect_frame("div one frame", frame_of(8'hc4, 5'h03));
      wr(A_DIVL, 32'h1);
      wr(A_GCTL, 32'h1);
   endtask : t_div_one

   task automatic t_double;
      remote_inst.nsamp = 10;
      wr(A_DATA, 32'h11);
      wr(A_DATA, 32'h22);
      expect_frame("first", frame_of(8'h11, 5'h03));
      expect_frame("second", frame_of(8'h22, 5'h03));
      remote_inst.nsamp = 12;
      rd_chk("tx event", A_STAT, 32'h2, 32'h2);
      wr(A_MASK, 32'h2);
      @(negedge clock);
      check("tx irq", 32'h1, {31'h0, irq});
      wr(A_STAT, 32'h2);
      @(negedge clock);
      check("tx irq clear", 32'h0, {31'h0, irq});
      wr(A_MASK, 32'h0);
   endtask : t_double

   task automatic t_rx;
      logic [31:0] q;
      wr(A_GCTL, 32'h29);
      remote_inst.send(8'ha5, 8, 1'b0, 1'b0, 1'b1);
      @(negedge clock);
      check("rts off", 32'h0, {31'h0, rts});
      check("dma reqs", 32'h3, {30'h0, rxd, txd});
      rd_chk("rx stat", A_STAT, 32'h10d, 32'h101);
      rd_chk("rx data", A_DATA, 32'hff, 32'ha5);
      repeat (2) @(negedge clock);
      check("rts on", 32'h1, {31'h0, rts});
      wr(A_STAT, 32'h1f);
      wr(A_LCTL, 32'h0b);
      remote_inst.send(8'h3c, 8, 1'b1, 1'b1, 1'b1);
      rd_chk("parity err", A_STAT, 32'h0c, 32'h04);
      wr(A_MASK, 32'h4);
      @(negedge clock);
      check("err irq", 32'h1, {31'h0, irq});
      wr(A_MASK, 32'h0);
      @(negedge clock);
      check("masked irq", 32'h0, {31'h0, irq});
      xfer(1'b0, A_DATA, 32'h0, q);
      wr(A_STAT, 32'h1f);
      remote_inst.send(8'h3c, 8, 1'b1, 1'b0, 1'b0);
      rd_chk("frame err", A_STAT, 32'h0c, 32'h08);
      xfer(1'b0, A_DATA, 32'h0, q);
      wr(A_STAT, 32'h1f);
   endtask : t_rx

   task automatic t_cts;
      wr(A_GCTL, 32'h11);
      wr(A_LCTL, 32'h3);
      remote_inst.cts_grant <= 1'b0;
      repeat (8) @(posedge clock);
      wr(A_DATA, 32'h5a);
      repeat (64) @(posedge clock);
      check("held", 32'h0, 32'(remote_inst.frames.size()));
      remote_inst.cts_grant <= 1'b1;
      expect_frame("granted", frame_of(8'h5a, 5'h03));
   endtask : t_cts

   task automatic results;
      if (err_total == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : results

   initial begin
      repeat (10) @(posedge clock);
      arst_n <= 1'b1;
      t_reset;
      t_tx_formats;
      t_div_one;
      t_double;
      t_rx;
      t_cts;
      results;
   end

   // the whole run needs well under a millisecond
   initial begin
      #2_000_000;
      err_total++;
      results;
   end
endmodule : async_serial_port_bench
`default_nettype wire
